/* msg_pkg.sv */
package msg_pkg;
  // Message area layout, byte index inside the 16-byte window
  localparam int unsigned AREA_BYTES    = 16;
  localparam int unsigned IDX_FUNC      = 0;
  localparam int unsigned IDX_REG_HI    = 1;
  localparam int unsigned IDX_REG_LO    = 2;
  localparam int unsigned IDX_COUNT     = 3;
  localparam int unsigned IDX_DATA      = 4;
  localparam int unsigned IDX_HS        = 15;
  // Handshake byte fields
  localparam int unsigned HS_TOGGLE_POS = 7;
  localparam int unsigned HS_CLEAR_POS  = 0;
  localparam int unsigned HS_STAT_LSB   = 5;
  localparam int unsigned HS_ALIVE_LSB  = 1;
  // Function codes and error answer
  localparam logic [7:0]  FC_READ       = 8'h03;
  localparam logic [7:0]  FC_LOOP       = 8'h08;
  localparam logic [7:0]  FC_WRITE      = 8'h10;
  localparam logic [7:0]  FC_PENDING    = 8'h00;
  localparam logic [7:0]  FC_ERR_BIT    = 8'h80;
  localparam logic [7:0]  ERR_COUNT     = 8'h02;
  localparam logic [7:0]  ERR_FUNC      = 8'h01;
  localparam logic [7:0]  ERR_SIZE      = 8'h03;
  // Alive counter timing
  localparam int unsigned CLK_HZ        = 40000000;
  localparam int unsigned ALIVE_MS      = 64;
  localparam int unsigned ALIVE_CYCLES  = CLK_HZ / 1000 * ALIVE_MS;
  // Drive answer latency inside the device, in cycles
  localparam int unsigned DRIVE_CYCLES  = 4;
  // Exchange state codes
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01,
    ST_WAIT = 2'b11,
    ST_RECV = 2'b10
  } xstate_t;
  localparam logic [1:0]  CODE_IDLE     = 2'b00;
  localparam logic [1:0]  CODE_SEND     = 2'b01;
  localparam logic [1:0]  CODE_WAIT     = 2'b10;
  localparam logic [1:0]  CODE_RECV     = 2'b11;
  // Host register map (APB word offsets)
  localparam logic [7:0]  A_CMD0        = 8'h00;
  localparam logic [7:0]  A_CMD1        = 8'h04;
  localparam logic [7:0]  A_CMD2        = 8'h08;
  localparam logic [7:0]  A_CMD3        = 8'h0c;
  localparam logic [7:0]  A_CTRL        = 8'h10;
  localparam logic [7:0]  A_RSP0        = 8'h14;
  localparam logic [7:0]  A_RSP1        = 8'h18;
  localparam logic [7:0]  A_RSP2        = 8'h1c;
  localparam logic [7:0]  A_RSP3        = 8'h20;
  localparam logic [7:0]  A_STAT        = 8'h24;
  localparam logic [7:0]  A_IRQ         = 8'h28;
  localparam logic [7:0]  A_MASK        = 8'h2c;
  localparam int unsigned CTRL_GO       = 0;
  localparam int unsigned CTRL_CLEAR    = 1;
  localparam int unsigned IRQ_DONE      = 0;
  localparam int unsigned IRQ_ERR       = 1;

  // Pick byte i of a 128-bit area, byte 0 in bits 7:0
  function automatic logic [7:0] area_byte(input logic [127:0] a, input int unsigned i);
    return a[i*8 +: 8];
  endfunction
endpackage

/* msg_if.sv */
interface msg_if;
  import msg_pkg::*;
  logic [127:0] out_area; // Master to device, bytes 16..31
  logic [127:0] in_area;  // Device to master, bytes 16..31
  modport master (output out_area, input in_area);
  modport device (input out_area, output in_area);
endinterface

/* alive_counter.sv */
module alive_counter
  import msg_pkg::*;
#(
  parameter int unsigned PERIOD = ALIVE_CYCLES
) (
  input  wire logic       core_clk_i, // 40 MHz clock
  input  wire logic       rstn_i,     // Sync reset, low
  output logic      [3:0] count_o     // Free-running count
);
  logic [31:0] tick;

  // Divide down and step the count once per period
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      tick    <= '0;
      count_o <= 4'h0;
    end else if (tick == PERIOD - 1) begin
      tick    <= '0;
      count_o <= count_o + 4'h1;
    end else begin
      tick    <= tick + 32'h1;
    end
  end
endmodule // alive_counter

/* msg_device.sv */
// Decided for this implementation: the register addresses and register access over APB.
module msg_device
  import msg_pkg::*;
#(
  parameter int unsigned ALIVE_PERIOD = ALIVE_CYCLES,
  parameter int unsigned DRIVE_LAT    = DRIVE_CYCLES
) (
  input  wire logic         core_clk_i,  // 40 MHz clock
  input  wire logic         rstn_i,      // Sync reset, low
  msg_if.device             link,        // Cyclic message area
  output logic      [15:0]  reg_addr_o,  // Register of the last legal write command
  output logic      [63:0]  wr_data_o,   // Words written by last command
  output logic              wr_stb_o,    // One-cycle write to drive
  input  wire logic [63:0]  rd_data_i    // Drive data for reads
);
  // Exchange sequencer state and its reported code
  xstate_t      state;
  logic [1:0]   code;
  logic [7:0]   wait_cnt;   // Cycles spent waiting on the drive
  logic         wait_done;  // Drive latency has run out

  // Command snapshot and response bytes
  logic [127:0] cmd;        // Snapshot taken at the toggle
  logic [119:0] rsp;        // Response bytes 0..14
  logic [7:0]   func;       // Function code of the snapshot
  logic [7:0]   cnt;        // Byte count of the snapshot
  logic         bad_func;   // Function code refused
  logic         bad_cnt;    // Byte count refused
  logic         cmd_ok;     // Command may reach the drive

  // Handshake bits
  logic         m_tgl;      // Master toggle as seen now
  logic         m_clr;      // Master clear as seen now
  logic         clr_d;      // Clear one cycle ago
  logic         tgl_seen;   // Last master toggle acted upon
  logic         tgl_echo;   // Toggle returned to master
  logic         start;      // Accept a new command this cycle

  // Alive count from the divider
  logic [3:0]   alive;

  // Legal function codes for a command
  function automatic logic func_ok(input logic [7:0] f);
    return f == FC_READ || f == FC_LOOP || f == FC_WRITE;
  endfunction

  // Legal byte counts for a command
  function automatic logic count_ok(input logic [7:0] c);
    return c == 8'h02 || c == 8'h04 || c == 8'h06 || c == 8'h08;
  endfunction

  // Error answer: flagged code, count 02, reason in byte 5, bits 15:8 of word 1
  function automatic logic [119:0] err_rsp(input logic [7:0] f, input logic f_bad);
    logic [119:0] r;
    r        = '0;
    r[7:0]   = f | FC_ERR_BIT;
    r[31:24] = ERR_COUNT;
    r[47:40] = f_bad ? ERR_FUNC : ERR_SIZE;
    return r;
  endfunction

  // Good answer: header echoed, data words by function
  function automatic logic [119:0] ok_rsp(input logic [127:0] c, input logic [63:0] d);
    logic [119:0] r;
    r       = '0;
    r[31:0] = c[31:0];
    if (area_byte(c, IDX_FUNC) == FC_READ) begin
      r[95:32] = d;
    end else if (area_byte(c, IDX_FUNC) == FC_LOOP) begin
      r[95:32] = c[95:32];
    end
    return r;
  endfunction

  // Handshake byte fields of the master's area
  assign m_tgl = link.out_area[IDX_HS*8 + HS_TOGGLE_POS];
  assign m_clr = link.out_area[IDX_HS*8 + HS_CLEAR_POS];

  // Only a toggle differing from the last served one starts work
  assign start = (state == ST_IDLE) && !m_clr && (m_tgl != tgl_seen);

  // Decode of the frozen command
  assign func     = area_byte(cmd, IDX_FUNC);
  assign cnt      = area_byte(cmd, IDX_COUNT);
  assign bad_func = !func_ok(func);
  assign bad_cnt  = !count_ok(cnt);
  assign cmd_ok   = !bad_func && !bad_cnt;

  // Drive latency reached on this cycle
  assign wait_done = (wait_cnt == 8'(DRIVE_LAT - 1));

  // Alive counter divider
  alive_counter #(.PERIOD(ALIVE_PERIOD)) i_alive_counter (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .count_o    (alive)
  );

  // Exchange sequencer
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i || m_clr) begin
      state    <= ST_IDLE;
      wait_cnt <= 8'h00;
    end else begin
      unique case (state)
        ST_IDLE: if (start) state <= ST_SEND;
        ST_SEND: begin
          state    <= ST_WAIT;
          wait_cnt <= 8'h00;
        end
        ST_WAIT: begin
          wait_cnt <= wait_cnt + 8'h01;
          if (wait_done) state <= ST_RECV;
        end
        ST_RECV: state <= ST_IDLE;
      endcase
    end
  end

  // Command snapshot, frozen until the next toggle
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      cmd <= '0;
    end else if (start) begin
      cmd <= link.out_area;
    end
  end

  // Toggle tracking and echo
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      tgl_seen <= 1'b0;
      tgl_echo <= 1'b0;
      clr_d    <= 1'b0;
    end else begin
      clr_d <= m_clr;
      // Served toggle forgets on clear
      if (m_clr) begin
        tgl_seen <= 1'b0;
      end else if (start) begin
        tgl_seen <= m_tgl;
      end
      // Echo drops when clear is released, else follows the response
      if (clr_d && !m_clr) begin
        tgl_echo <= 1'b0;
      end else if (state == ST_RECV) begin
        tgl_echo <= tgl_seen;
      end
    end
  end

  // Write strobe to the drive, one cycle, for a legal write command
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      wr_stb_o   <= 1'b0;
      wr_data_o  <= '0;
      reg_addr_o <= 16'h0000;
    end else begin
      wr_stb_o <= 1'b0;
      if (state == ST_SEND && cmd_ok && func == FC_WRITE) begin
        wr_stb_o   <= 1'b1;
        wr_data_o  <= cmd[IDX_DATA*8 +: 64];
        reg_addr_o <= {area_byte(cmd, IDX_REG_HI), area_byte(cmd, IDX_REG_LO)};
      end
    end
  end

  // Response build; code shows pending until the answer is ready
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      rsp <= '0;
    end else if (state == ST_SEND) begin
      rsp[7:0] <= FC_PENDING;
    end else if (state == ST_RECV) begin
      if (cmd_ok) begin
        rsp <= ok_rsp(cmd, rd_data_i);
      end else begin
        rsp <= err_rsp(func, bad_func);
      end
    end
  end

  // Exchange state code for the handshake byte
  always_comb begin
    unique case (state)
      ST_IDLE: code = CODE_IDLE;
      ST_SEND: code = CODE_SEND;
      ST_WAIT: code = CODE_WAIT;
      ST_RECV: code = CODE_RECV;
    endcase
  end

  // Incoming handshake byte: toggle, state, alive count
  assign link.in_area = {tgl_echo, code, alive, 1'b0, rsp};
endmodule // msg_device

/* msg_master.sv */
module msg_master
  import msg_pkg::*;
(
  input  wire logic        core_clk_i, // 40 MHz clock
  input  wire logic        rstn_i,     // Sync reset, low
  msg_if.master            link,       // Cyclic message area
  input  wire logic        psel,       // APB select
  input  wire logic        penable,    // APB enable
  input  wire logic        pwrite,     // APB direction
  input  wire logic [7:0]  paddr,      // APB address
  input  wire logic [31:0] pwdata,     // APB write data
  output logic      [31:0] prdata,     // APB read data
  output logic             pready,     // APB ready
  output logic             pslverr,    // APB error
  output logic             irq_o       // Interrupt level
);
  logic [127:0] cmd;
  logic         tgl;
  logic         clr;
  logic         busy;
  logic [1:0]   irq_stat;
  logic [1:0]   irq_mask;
  logic         match;
  logic [7:0]   rfunc;
  logic         wr;
  logic         rd;
  logic         mapped;

  assign wr     = psel && penable && pwrite;
  assign rd     = psel && penable && !pwrite;
  assign match  = link.in_area[127] == tgl;
  assign rfunc  = area_byte(link.in_area, IDX_FUNC);
  assign mapped = paddr <= A_MASK && paddr[1:0] == 2'b00;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // Command words, toggle and clear; toggle flips on a GO write to CTRL while not busy and not clearing
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      cmd  <= '0;
      tgl  <= 1'b0;
      clr  <= 1'b0;
      busy <= 1'b0;
    end else begin
      if (wr && paddr <= A_CMD3 && !busy) cmd[paddr[3:2]*32 +: 32] <= pwdata;
      if (wr && paddr == A_CTRL) begin
        clr <= pwdata[CTRL_CLEAR];
        if (pwdata[CTRL_CLEAR]) begin
          tgl  <= 1'b0;
          busy <= 1'b0;
        end else if (pwdata[CTRL_GO] && !busy && !clr) begin
          tgl  <= ~tgl;
          busy <= 1'b1;
        end
      end else if (busy && match && rfunc != FC_PENDING) begin
        busy <= 1'b0;
      end
    end
  end

  // Sticky events, cleared by reading the IRQ register
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      irq_stat <= 2'b00;
      irq_mask <= 2'b00;
    end else begin
      if (wr && paddr == A_MASK) irq_mask <= pwdata[1:0];
      irq_stat <= (rd && paddr == A_IRQ) ? 2'b00 : irq_stat;
      if (busy && match && rfunc != FC_PENDING && !(wr && paddr == A_CTRL)) begin
        irq_stat[IRQ_DONE] <= 1'b1;
        if (rfunc[7]) irq_stat[IRQ_ERR] <= 1'b1;
      end
    end
  end

  assign irq_o = |(irq_stat & irq_mask);
  assign link.out_area = {tgl, 6'h00, clr, cmd[119:0]};

  always_comb begin
    unique case (paddr)
      A_CMD0, A_CMD1, A_CMD2, A_CMD3: prdata = cmd[paddr[3:2]*32 +: 32];
      A_CTRL: prdata = {30'h0, clr, busy};
      A_RSP0: prdata = link.in_area[31:0];
      A_RSP1: prdata = link.in_area[63:32];
      A_RSP2: prdata = link.in_area[95:64];
      A_RSP3: prdata = link.in_area[127:96];
      A_STAT: prdata = {30'h0, match, busy};
      A_IRQ:  prdata = {30'h0, irq_stat};
      A_MASK: prdata = {30'h0, irq_mask};
      default: prdata = 32'h0;
    endcase
  end
endmodule // msg_master

/* msg_handshake_asserts.sv */
module msg_handshake_asserts
  import msg_pkg::*;
#(
  parameter int unsigned ALIVE_PERIOD = ALIVE_CYCLES
) (
  input wire logic         core_clk_i, // Clock
  input wire logic         rstn_i,     // Sync reset, low
  input wire logic [127:0] out_area,   // Master to device
  input wire logic [127:0] in_area     // Device to master
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        tg, cl, ec, ok;
  logic [1:0]  st;
  logic [3:0]  al;
  int unsigned quiet;
  // Handshake byte fields and a well-formed command
  assign tg = out_area[127];
  assign cl = out_area[120];
  assign ec = in_area[127];
  assign st = in_area[126:125];
  assign al = in_area[124:121];
  assign ok = out_area[7:0] inside {FC_READ, FC_LOOP, FC_WRITE} &&
              out_area[31:24] inside {8'h02, 8'h04, 8'h06, 8'h08};
  // Cycles since the alive counter last moved
  always_ff @(posedge core_clk_i)
    quiet <= (!rstn_i || $changed(al)) ? 0 : quiet + 1;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  a_clear_forces_tog: assert property (cl |=> !tg)
    else $error("toggle not cleared");
  a_reset_zero: assert property ($rose(rstn_i) |-> !tg && !ec)
    else $error("toggle not zero after reset");
  a_echo_clear: assert property ($fell(cl) |-> ##[0:2] !ec)
    else $error("echo not zero after clear");
  a_echo_follows: assert property ($changed(ec) |-> ec == tg)
    else $error("echo moved away from toggle");
  a_echo_latency: assert property ($changed(tg) && !cl |-> ##[1:12] ec == tg)
    else $error("no answer to toggle");
  a_state_seq: assert property ($changed(tg) && ok |->
    ##[1:3] st == CODE_SEND ##1 st == CODE_WAIT)
    else $error("exchange state sequence wrong");
  a_pending_code: assert property (st == CODE_WAIT |-> in_area[7:0] == FC_PENDING)
    else $error("pending code not shown");
  a_err_count: assert property (ec == tg && in_area[7] |-> in_area[31:24] == ERR_COUNT)
    else $error("error count wrong");
  a_rsp_stands: assert property ($stable(tg) && !cl && ec == tg && $past(ec == tg)
    |-> $stable(in_area[119:0]))
    else $error("response changed while served");
  a_alive_step: assert property ($changed(al) |-> al == $past(al) + 4'h1)
    else $error("alive counter step wrong");
  a_alive_period: assert property (quiet <= ALIVE_PERIOD)
    else $error("alive counter stalled");
endmodule // msg_handshake_asserts

/* test_fieldbus_modbus_msg_handshake.sv */
module test_fieldbus_modbus_msg_handshake
  import msg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] T_C0 [5] = '{32'h02800210, 32'h08001003, 32'h02001108,
                                       32'h02000005, 32'h03000003};
  localparam logic [31:0] T_E0 [5] = '{32'h02800210, 32'h00001003, 32'h00000008,
                                       32'h02000085, 32'h02000083};
  localparam logic [31:0] T_M0 [5] = '{'1, 32'h00ffffff, 32'hff, 32'hff0000ff, 32'hff0000ff};
  localparam logic [31:0] T_E1 [5] = '{0, 0, 0, 32'h0100, 32'h0300};
  localparam logic [31:0] T_M1 [5] = '{'1, '1, '1, 32'hff00, 32'hff00};
  logic        core_clk_i = 1'b0, rstn_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, c1;
  logic [63:0] rd_data = 64'h0, wr_data;
  logic        pready, pslverr, irq_o, wr_stb, tog = 1'b0;
  logic [15:0] reg_addr, lfsr = 16'h4a9a;
  logic [3:0]  alive;
  logic [64:0] rq[$], e;
  logic [79:0] wq[$];
  int          num_errors = 0, samples_checked = 0, cycles = 0;
  msg_if link();
  msg_master i_msg_master (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .link(link),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_o(irq_o));
  msg_device #(.ALIVE_PERIOD(16)) i_msg_device (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
    .link(link), .reg_addr_o(reg_addr), .wr_data_o(wr_data), .wr_stb_o(wr_stb),
    .rd_data_i(rd_data));
  msg_handshake_asserts #(.ALIVE_PERIOD(16)) i_msg_handshake_asserts (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .out_area(link.out_area), .in_area(link.in_area));
  // 40 MHz clock
  initial begin
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  // Random source: 16-bit shift register step
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic final_report();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [79:0] seen, input logic [79:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Hang guard
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      final_report();
    end
  end
  // Result watcher: oldest note against each read and drive write
  always @(posedge core_clk_i) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      e = rq.size() ? rq.pop_front() : 65'h1_0000_0000_dead_beef;
      chk("prdata", prdata & e[63:32], e[31:0]);
      chk("pslverr", pslverr, e[64]);
    end
    if (wr_stb === 1'b1) chk("drive write", {reg_addr, wr_data}, wq.size() ? wq.pop_front() : 0);
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk_i);
    penable <= 1'b1;
    do @(posedge core_clk_i); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
    rq.push_back({a == 8'h3c, m, x & m});
    apb(1'b0, a, 32'h0);
  endtask
  task automatic cmd(input logic [31:0] c0, input logic [31:0] w1);
    apb(1'b1, A_CMD0, c0);
    apb(1'b1, A_CMD1, w1);
    apb(1'b1, A_CMD2, 32'h0);
    apb(1'b1, A_CMD3, 32'h0);
    apb(1'b1, A_CTRL, 32'h1);
    apb(1'b1, A_CTRL, 32'h1); // Second start lands while busy
    tog = ~tog;
    for (int i = 0; i < 40 && link.in_area[127] !== tog; i++) @(posedge core_clk_i);
    chk("toggle out", link.out_area[127], tog);
    chk("toggle echo", link.in_area[127], tog);
    chk("command head", link.out_area[63:0], {w1, c0});
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    rd(A_STAT, 2, '1);
    rd(A_IRQ, 0, '1);
    rd(8'h3c, 0, '1);
    chk("reset toggles", {link.out_area[127], link.in_area[127]}, 0);
    $display("test reset done");
    apb(1'b1, A_MASK, 32'h3);
    for (int k = 0; k < 5; k++) begin
      lfsr = lfsr_next(lfsr);
      rd_data <= {8{lfsr[7:0]}};
      c1 = {16'h0, lfsr[7:0], lfsr[15:8]};
      if (k == 0) wq.push_back({16'h0280, 32'h0, c1});
      cmd(T_C0[k], c1);
      @(posedge core_clk_i);
      chk("irq raised", irq_o, 1'b1);
      rd(A_RSP0, T_E0[k], T_M0[k]);
      rd(A_RSP1, k == 1 ? rd_data[31:0] : k == 2 ? c1 : T_E1[k], T_M1[k]);
      rd(A_IRQ, k > 2 ? 2 : 1, k > 2 ? 2 : 1);
      rd(A_IRQ, 0, 3);
      @(posedge core_clk_i);
      chk("irq cleared", irq_o, 1'b0);
      rd(A_STAT, 2, 3);
      $display("test command %0d done", k);
    end
    apb(1'b1, A_CMD0, 32'h0);
    rd(A_RSP0, T_E0[4], T_M0[4]);
    apb(1'b1, A_CTRL, 32'h2);
    @(posedge core_clk_i);
    chk("clear toggle", {link.out_area[127], link.out_area[120]}, 2'b01);
    apb(1'b1, A_CTRL, 32'h0);
    repeat (3) @(posedge core_clk_i);
    chk("clear echo", link.in_area[127], 1'b0);
    tog = 1'b0;
    $display("test clear done");
    apb(1'b1, A_MASK, 32'h0);
    cmd(T_C0[2], 32'h0);
    @(posedge core_clk_i);
    chk("irq masked", irq_o, 1'b0);
    rd(A_IRQ, 1, 1);
    alive = link.in_area[124:121];
    repeat (16) @(posedge core_clk_i);
    chk("alive step", link.in_area[124:121], 4'(alive + 4'h1));
    $display("test mask and alive done");
    final_report();
  end
endmodule // test_fieldbus_modbus_msg_handshake
